/* ctg_phase_timer.sv */
// Purpose: Counts time base ticks for one trigger phase
// Assumes: load and tick are synchronous one-cycle enables
// Notes:   A phase lasts load_value plus one ticks
`timescale 1ns/1ps
module ctg_phase_timer #(parameter int CNT_W = 24)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    ctg_timer_if.timer tif
);

    typedef struct packed
    {
        logic active;
        logic [CNT_W-1:0] cnt;
    } ctg_timer_state_t;

    ctg_timer_state_t st;
    ctg_timer_state_t next_st;

    // ======================================================================
    // Counter
    // Expiry ignores load so that a reload on expiry forms no loop
    assign tif.expired = tif.tick && st.active && (st.cnt == '0);

    always_comb
    begin
        next_st = st;
        if (tif.load)
        begin
            next_st.active = 1'b1;
            next_st.cnt = tif.load_value;
        end
        else if (tif.tick && st.active)
        begin
            // each phase lasts value plus one
            if (st.cnt == '0)
                next_st.active = 1'b0;
            else
                next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    // ======================================================================
    // Checks
    a_timer_len_exact: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (tif.load && tif.load_value == '0) ##1 (!tif.load && tif.tick) |-> tif.expired)
        else $error("Zero count did not expire on first tick");

endmodule

/* ctg_pkg.sv */
// Purpose: Shared constants and types of the camera trigger generator
// Assumes: 50 MHz system clock, AHB-Lite register access with 32-bit data
// Notes:   Register indices are word indices; byte address is index times four
package ctg_pkg;

    // ======================================================================
    // Timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned BASE_HZ = 25_000_000;
    localparam int unsigned BASE_DIV = CLK_HZ / BASE_HZ;
    localparam logic [3:0] BASE_DIV_LAST = 4'(BASE_DIV - 1);

    // ======================================================================
    // Register indices
    localparam logic [7:0] IDX_CTL = 8'h18;
    localparam logic [7:0] IDX_HI_U = 8'h19;
    localparam logic [7:0] IDX_HI_L = 8'h1A;
    localparam logic [7:0] IDX_LO_U = 8'h1B;
    localparam logic [7:0] IDX_LO_L = 8'h1C;
    localparam logic [7:0] IDX_NONE = 8'hFF;

    // ======================================================================
    // Control field positions
    localparam int CTL_SRC_MSB = 7;
    localparam int CTL_SRC_LSB = 4;
    localparam int CTL_ONESHOT = 3;
    localparam int CTL_IDLE = 2;
    localparam int CTL_SCHEME = 1;
    localparam int CTL_GEN = 0;

    // ======================================================================
    // Reset values
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_HI_U = 8'h00;
    localparam logic [7:0] RST_HI_L = 8'h00;
    localparam logic [7:0] RST_LO_U = 8'h00;
    localparam logic [7:0] RST_LO_L = 8'h00;

    // ======================================================================
    // Source select codes
    localparam logic [3:0] SRC_PORT0 = 4'h0;
    localparam logic [3:0] SRC_PORT1 = 4'h1;
    localparam logic [1:0] SRC_BASE_TOP = 2'h1;
    localparam logic [3:0] SRC_EXT_LAST = 4'hE;

    localparam int CNT_W = 24;

    typedef enum logic [1:0]
    {
        CTG_IDLE = 2'b00,
        CTG_RUN = 2'b01,
        CTG_SHOT = 2'b10
    } ctg_fsm_t;

endpackage

/* ctg_sensor_model.sv */
// Purpose: Far-side stand-in: back-channel frame ticks and trigger capture
// Assumes: Frame ticks run free, one clock wide, synchronous to clock_i
// Notes:   Tick spacing is set by parameters so each source times differently
`timescale 1ns/1ps
module ctg_sensor_model
#(
    parameter int P0 = 3,
    parameter int P1 = 5
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic camera_trigger_i,
    output logic tick0_o,
    output logic tick1_o,
    output logic [15:0] pulses_o
);
    // ======================================================================
    // Tick generation and pulse capture
    logic [7:0] cnt0;
    logic [7:0] cnt1;
    logic last;

    // Unequal spacings let the bench tell port 0 from port 1
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt0 <= 8'h00;
            cnt1 <= 8'h00;
            tick0_o <= 1'b0;
            tick1_o <= 1'b0;
            pulses_o <= 16'h0000;
            last <= 1'b0;
        end
        else
        begin
            cnt0 <= (cnt0 == 8'(P0 - 1)) ? 8'h00 : cnt0 + 8'h01;
            cnt1 <= (cnt1 == 8'(P1 - 1)) ? 8'h00 : cnt1 + 8'h01;
            tick0_o <= (cnt0 == 8'(P0 - 1));
            tick1_o <= (cnt1 == 8'(P1 - 1));
            last <= camera_trigger_i;
            if (camera_trigger_i && !last)
            begin
                pulses_o <= pulses_o + 16'h0001;
            end
        end
    end
endmodule

/* ctg_timer_if.sv */
// Purpose: Carries phase timer control and expiry between trigger logic and timer
// Assumes: One clock domain
// Notes:   tick is the selected time base enable
`timescale 1ns/1ps
interface ctg_timer_if #(parameter int CNT_W = 24);
    logic tick;
    logic load;
    logic [CNT_W-1:0] load_value;
    logic expired;

    modport ctrl (output tick, output load, output load_value, input expired);
    modport timer (input tick, input load, input load_value, output expired);
endinterface

/* ctg_trigger_top.sv */
// Purpose: Camera trigger generator with AHB-Lite register bank
// Assumes: Back-channel frame ticks and GPIO inputs are synchronous to clock_i
// Notes:   Reads insert one wait state; writes complete with no wait state
`timescale 1ns/1ps
module ctg_trigger_top
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic bc_tick0_i,
    input wire logic bc_tick1_i,
    input wire logic [6:0] gpio_i,
    output logic camera_trigger_o
);

    typedef struct packed
    {
        logic [7:0] ctl;
        logic [7:0] hi_u;
        logic [7:0] hi_l;
        logic [7:0] lo_u;
        logic [7:0] lo_l;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic rd_pend;
        logic [7:0] rd_idx;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic [3:0] div_cnt;
        logic base_tick;
        logic shot_req;
        ctg_pkg::ctg_fsm_t fsm;
        logic trig;
    } ctg_state_t;

    localparam ctg_state_t ST_RESET = '{
        ctl: ctg_pkg::RST_CTL,
        hi_u: ctg_pkg::RST_HI_U,
        hi_l: ctg_pkg::RST_HI_L,
        lo_u: ctg_pkg::RST_LO_U,
        lo_l: ctg_pkg::RST_LO_L,
        wr_pend: 1'b0,
        wr_idx: ctg_pkg::IDX_NONE,
        rd_pend: 1'b0,
        rd_idx: ctg_pkg::IDX_NONE,
        hrdata: 32'h0000_0000,
        hready: 1'b1,
        hresp: 1'b0,
        div_cnt: 4'h0,
        base_tick: 1'b0,
        shot_req: 1'b0,
        fsm: ctg_pkg::CTG_IDLE,
        trig: 1'b0
    };

    ctg_state_t st;
    ctg_state_t next_st;
    logic [1:0] rst_q;
    logic rst_n;
    logic sel_tick;
    logic tmr_load;
    logic [ctg_pkg::CNT_W-1:0] tmr_value;
    logic accept;
    logic [3:0] src;
    logic ext_mode;
    logic int_mode;
    logic idle_lvl;
    ctg_timer_if #(.CNT_W(ctg_pkg::CNT_W)) tif ();

    // ======================================================================
    // Functions
    function automatic logic is_internal(input logic [3:0] code);
        is_internal = (code == ctg_pkg::SRC_PORT0) || (code == ctg_pkg::SRC_PORT1)
            || (code[3:2] == ctg_pkg::SRC_BASE_TOP);
    endfunction
    function automatic logic is_external(input logic [3:0] code);
        is_external = code[3] && (code <= ctg_pkg::SRC_EXT_LAST);
    endfunction
    // Count for the phase whose output level is lvl
    function automatic logic [ctg_pkg::CNT_W-1:0] phase_count(
        input logic lvl,
        input ctg_state_t s
    );
        if (s.ctl[ctg_pkg::CTL_SCHEME])
            phase_count = {s.hi_l, s.lo_u, s.lo_l};
        else if (lvl)
            phase_count = {8'h00, s.hi_u, s.hi_l};
        else
            phase_count = {8'h00, s.lo_u, s.lo_l};
    endfunction

    function automatic logic [7:0] read_reg(input logic [7:0] idx, input ctg_state_t s);
        if (idx == ctg_pkg::IDX_CTL)
            read_reg = s.ctl & ~(8'h01 << ctg_pkg::CTL_ONESHOT);
        else if (idx == ctg_pkg::IDX_HI_U)
            read_reg = s.hi_u;
        else if (idx == ctg_pkg::IDX_HI_L)
            read_reg = s.hi_l;
        else if (idx == ctg_pkg::IDX_LO_U)
            read_reg = s.lo_u;
        else if (idx == ctg_pkg::IDX_LO_L)
            read_reg = s.lo_l;
        else
            read_reg = 8'h00;
    endfunction

    // ======================================================================
    // Reset release
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_q <= 2'b00;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // ======================================================================
    // Source decode and time base
    assign src = st.ctl[ctg_pkg::CTL_SRC_MSB:ctg_pkg::CTL_SRC_LSB];
    assign ext_mode = is_external(src);
    assign int_mode = is_internal(src);
    assign idle_lvl = st.ctl[ctg_pkg::CTL_IDLE];
    assign accept = hsel_i && htrans_i[1] && hready_i && st.hready;

    always_comb
    begin
        if (src == ctg_pkg::SRC_PORT0)
            sel_tick = bc_tick0_i;
        else if (src == ctg_pkg::SRC_PORT1)
            sel_tick = bc_tick1_i;
        else if (src[3:2] == ctg_pkg::SRC_BASE_TOP)
            sel_tick = st.base_tick;
        // reserved codes give no time base
        else
            sel_tick = 1'b0;
    end

    assign tif.tick = sel_tick;
    assign tif.load = tmr_load;
    assign tif.load_value = tmr_value;
    ctg_phase_timer #(.CNT_W(ctg_pkg::CNT_W)) u_timer
    (
        .clock_i(clock_i),
        .rst_n_i(rst_n),
        .tif(tif.timer)
    );

    // ======================================================================
    // Next state
    always_comb
    begin
        next_st = st;
        tmr_load = 1'b0;
        tmr_value = '0;

        // Divider for the 25 MHz enable
        if (st.div_cnt == ctg_pkg::BASE_DIV_LAST)
            next_st.div_cnt = 4'h0;
        else
            next_st.div_cnt = st.div_cnt + 4'h1;
        next_st.base_tick = (st.div_cnt == ctg_pkg::BASE_DIV_LAST);

        // Bus address phase
        next_st.wr_pend = accept && hwrite_i;
        next_st.shot_req = 1'b0;
        if (accept)
        begin
            if (haddr_i[31:10] == 22'h0)
            begin
                next_st.wr_idx = haddr_i[9:2];
                next_st.rd_idx = haddr_i[9:2];
            end
            else
            begin
                next_st.wr_idx = ctg_pkg::IDX_NONE;
                next_st.rd_idx = ctg_pkg::IDX_NONE;
            end
            // Wait state lets a preceding write land before the read samples
            if (!hwrite_i)
            begin
                next_st.rd_pend = 1'b1;
                next_st.hready = 1'b0;
            end
        end
        if (st.rd_pend)
        begin
            next_st.rd_pend = 1'b0;
            next_st.hready = 1'b1;
            next_st.hrdata = {24'h000000, read_reg(st.rd_idx, st)};
        end
        next_st.hresp = 1'b0;

        // Bus write data phase
        if (st.wr_pend)
        begin
            if (st.wr_idx == ctg_pkg::IDX_CTL)
            begin
                next_st.ctl = hwdata_i[7:0] & ~(8'h01 << ctg_pkg::CTL_ONESHOT);
                next_st.shot_req = hwdata_i[ctg_pkg::CTL_ONESHOT];
            end
            else if (st.wr_idx == ctg_pkg::IDX_HI_U)
                next_st.hi_u = hwdata_i[7:0];
            else if (st.wr_idx == ctg_pkg::IDX_HI_L)
                next_st.hi_l = hwdata_i[7:0];
            else if (st.wr_idx == ctg_pkg::IDX_LO_U)
                next_st.lo_u = hwdata_i[7:0];
            else if (st.wr_idx == ctg_pkg::IDX_LO_L)
                next_st.lo_l = hwdata_i[7:0];
        end

        // Trigger sequencer
        case (st.fsm)
            ctg_pkg::CTG_IDLE:
            begin
                next_st.trig = idle_lvl;
                if (ext_mode)
                    next_st.trig = gpio_i[src[2:0]];
                // Start waits for a tick so every phase spans whole base periods
                else if (int_mode && (st.ctl[ctg_pkg::CTL_GEN] || st.shot_req) && !sel_tick)
                    next_st.shot_req = st.shot_req;
                else if (st.ctl[ctg_pkg::CTL_GEN] && int_mode)
                begin
                    next_st.fsm = ctg_pkg::CTG_RUN;
                    tmr_load = 1'b1;
                    tmr_value = phase_count(idle_lvl, st);
                end
                // a single request gives one pulse
                else if (st.shot_req && int_mode)
                begin
                    // pulse opposite idle for high count
                    next_st.fsm = ctg_pkg::CTG_SHOT;
                    next_st.trig = !idle_lvl;
                    tmr_load = 1'b1;
                    tmr_value = phase_count(1'b1, st);
                end
            end
            ctg_pkg::CTG_RUN:
            begin
                if (!st.ctl[ctg_pkg::CTL_GEN] || !int_mode)
                begin
                    next_st.fsm = ctg_pkg::CTG_IDLE;
                    next_st.trig = idle_lvl;
                end
                else if (tif.expired)
                begin
                    next_st.trig = !st.trig;
                    tmr_load = 1'b1;
                    tmr_value = phase_count(!st.trig, st);
                end
            end
            ctg_pkg::CTG_SHOT:
            begin
                if (tif.expired || !int_mode)
                begin
                    next_st.fsm = ctg_pkg::CTG_IDLE;
                    next_st.trig = idle_lvl;
                end
            end
            default:
            begin
                next_st.fsm = ctg_pkg::CTG_IDLE;
                next_st.trig = idle_lvl;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n)
    begin
        if (!rst_n)
            st <= ST_RESET;
        else
            st <= next_st;
    end

    assign hrdata_o = st.hrdata;
    assign hreadyout_o = st.hready;
    assign hresp_o = st.hresp;
    assign camera_trigger_o = st.trig;

    // ======================================================================
    // Checks
    a_oneshot_reads_zero: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.rd_pend && st.rd_idx == ctg_pkg::IDX_CTL) |=> !hrdata_o[ctg_pkg::CTL_ONESHOT])
        else $error("One-shot bit read back as one");
    a_idle_level_held: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.fsm == ctg_pkg::CTG_IDLE && !ext_mode && !st.shot_req)
        |=> camera_trigger_o == $past(idle_lvl))
        else $error("Output left idle level while idle");
    a_ext_passthrough: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.fsm == ctg_pkg::CTG_IDLE && ext_mode)
        |=> camera_trigger_o == $past(gpio_i[src[2:0]]))
        else $error("External GPIO not passed to output");
    a_gen_stops: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.fsm == ctg_pkg::CTG_RUN && !st.ctl[ctg_pkg::CTL_GEN])
        |=> st.fsm == ctg_pkg::CTG_IDLE ##1 camera_trigger_o == $past(idle_lvl, 2))
        else $error("Generation continued after disable");
    a_toggle_on_expire: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.fsm == ctg_pkg::CTG_RUN && tif.expired && st.ctl[ctg_pkg::CTL_GEN] && int_mode)
        |=> camera_trigger_o != $past(camera_trigger_o))
        else $error("Output did not toggle at phase expiry");
    a_base_tick_rate: assert property (@(posedge clock_i) disable iff (!rst_n)
        st.base_tick |=> !st.base_tick ##1 st.base_tick)
        else $error("25 MHz enable has wrong period");
    a_port_tick_sel: assert property (@(posedge clock_i) disable iff (!rst_n)
        (src == ctg_pkg::SRC_PORT1) |-> (tif.tick == bc_tick1_i))
        else $error("Port 1 frame clock not selected");
    a_shot_level: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.fsm == ctg_pkg::CTG_SHOT) |-> (camera_trigger_o == !idle_lvl))
        else $error("One-shot pulse at wrong level");
    a_fifty_count: assert property (@(posedge clock_i) disable iff (!rst_n)
        (tmr_load && st.ctl[ctg_pkg::CTL_SCHEME])
        |-> tmr_value == {st.hi_l, st.lo_u, st.lo_l})
        else $error("50/50 count assembled wrongly");
    a_hilo_count: assert property (@(posedge clock_i) disable iff (!rst_n)
        (tmr_load && !st.ctl[ctg_pkg::CTL_SCHEME] && st.fsm == ctg_pkg::CTG_RUN && st.trig)
        |-> tmr_value == {8'h00, st.lo_u, st.lo_l})
        else $error("Low phase loaded wrong count");
    a_write_lands: assert property (@(posedge clock_i) disable iff (!rst_n)
        (st.wr_pend && st.wr_idx == ctg_pkg::IDX_HI_U) |=> st.hi_u == $past(hwdata_i[7:0]))
        else $error("High count upper byte not written");

endmodule

/* tb.sv */
// Purpose: Self-checking bench for the camera trigger generator
// Assumes: Single AHB-Lite master, 25 MHz base is a tick every 2nd clock
// Notes:   Phase lengths are measured in clocks on the trigger output
`timescale 1ns/1ps
module tb;
    logic clock_i;
    logic rst_n_i;
    logic hsel_i;
    logic [31:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic bc_tick0_i;
    logic bc_tick1_i;
    logic [6:0] gpio_i;
    logic camera_trigger_o;
    logic [15:0] pulses;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int hi;
    int lo;
    int c;
    logic [31:0] rd;
    logic [15:0] p0;
    logic [7:0] regs [5];

    ctg_trigger_top i_ctg_trigger_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .bc_tick0_i(bc_tick0_i),
        .bc_tick1_i(bc_tick1_i), .gpio_i(gpio_i), .camera_trigger_o(camera_trigger_o));

    ctg_sensor_model #(.P0(3), .P1(5)) i_ctg_sensor_model (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .camera_trigger_i(camera_trigger_o), .tick0_o(bc_tick0_i),
        .tick1_o(bc_tick1_i), .pulses_o(pulses));

    // ======================================================================
    // Clock, timeout and verdict
    initial
    begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    // Whole run needs under a thousand clocks; the ceiling leaves wide margin
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
        end
    endtask

    // ======================================================================
    // Bus access: called just after a rising edge, ends on one
    task automatic xfer(input logic is_wr, input logic [7:0] idx, input logic [31:0] wd,
        output logic [31:0] rdat);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        haddr_i <= {22'h000000, idx, 2'b00};
        hwrite_i <= is_wr;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rdat = hrdata_o;
        check({31'h0, hresp_o}, 32'h0, "okay response");
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] d;
        xfer(1'b1, idx, {24'hFFFFFF, v}, d);
    endtask

    task automatic cfg(input logic [7:0] hu, input logic [7:0] hl, input logic [7:0] lu,
        input logic [7:0] ll);
        wr(ctg_pkg::IDX_HI_U, hu);
        wr(ctg_pkg::IDX_HI_L, hl);
        wr(ctg_pkg::IDX_LO_U, lu);
        wr(ctg_pkg::IDX_LO_L, ll);
    endtask

    // ======================================================================
    // Trigger measurement
    task automatic phases(output int h, output int l);
        h = 0;
        l = 0;
        while (camera_trigger_o !== 1'b0) @(posedge clock_i);
        while (camera_trigger_o !== 1'b1) @(posedge clock_i);
        while (camera_trigger_o === 1'b1)
        begin
            h++;
            @(posedge clock_i);
        end
        while (camera_trigger_o === 1'b0)
        begin
            l++;
            @(posedge clock_i);
        end
    endtask

    task automatic count_lvl(input logic lvl, input int n, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge clock_i);
            if (camera_trigger_o === lvl) k++;
        end
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        rst_n_i = 1'b0;
        hsel_i = 1'b0;
        haddr_i = 32'h0;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'h2;
        hwdata_i = 32'h0;
        gpio_i = 7'h00;
        regs = '{ctg_pkg::IDX_CTL, ctg_pkg::IDX_HI_U, ctg_pkg::IDX_HI_L, ctg_pkg::IDX_LO_U,
            ctg_pkg::IDX_LO_L};
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        for (int i = 0; i < 5; i++)
        begin
            xfer(1'b0, regs[i], 32'h0, rd);
            check(rd, 32'h0, "reset value");
        end
        for (int i = 1; i < 5; i++)
        begin
            wr(regs[i], 8'hA5 ^ 8'(i));
            xfer(1'b0, regs[i], 32'h0, rd);
            check(rd, {24'h0, 8'hA5 ^ 8'(i)}, "count byte readback");
        end
        wr(8'h17, 8'hAB);
        xfer(1'b0, 8'h17, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        // Hi/lo scheme on every 25 MHz code; reserved codes never written
        cfg(8'h00, 8'h02, 8'h00, 8'h05);
        for (int k = 4; k < 8; k++)
        begin
            wr(ctg_pkg::IDX_CTL, {4'(k), 4'b0001});
            xfer(1'b0, ctg_pkg::IDX_CTL, 32'h0, rd);
            check(rd, {24'h0, 4'(k), 4'b0001}, "control readback");
            phases(hi, lo);
            check(hi, 6, "hi/lo high phase");
            check(lo, 12, "hi/lo low phase");
            wr(ctg_pkg::IDX_CTL, 8'h40);
        end
        // Upper high byte must be ignored by the 24-bit count
        cfg(8'h07, 8'h00, 8'h00, 8'h03);
        wr(ctg_pkg::IDX_CTL, 8'h43);
        phases(hi, lo);
        check(hi, 8, "50/50 high phase");
        check(lo, 8, "50/50 low phase");
        wr(ctg_pkg::IDX_CTL, 8'h40);
        // Frame ticks: port 0 every 3 clocks, port 1 every 5
        cfg(8'h00, 8'h01, 8'h00, 8'h01);
        for (int k = 0; k < 2; k++)
        begin
            wr(ctg_pkg::IDX_CTL, {4'(k), 4'b0001});
            phases(hi, lo);
            check(hi, 6 + 4 * k, "frame tick high phase");
            check(lo, 6 + 4 * k, "frame tick low phase");
            wr(ctg_pkg::IDX_CTL, 8'h00);
        end
        // Idle level held while disabled, then across an enable and disable
        wr(ctg_pkg::IDX_CTL, 8'h44);
        repeat (2) @(posedge clock_i);
        count_lvl(1'b1, 30, c);
        check(c, 30, "idle level high");
        wr(ctg_pkg::IDX_CTL, 8'h45);
        count_lvl(1'b1, 3, c);
        check(c, 3, "first phase at idle level");
        wr(ctg_pkg::IDX_CTL, 8'h44);
        repeat (2) @(posedge clock_i);
        count_lvl(1'b1, 40, c);
        check(c, 40, "stopped after disable");
        // One-shot with enable kept low and full pulse waited out
        cfg(8'h00, 8'h03, 8'h00, 8'h00);
        wr(ctg_pkg::IDX_CTL, 8'h40);
        repeat (2) @(posedge clock_i);
        check({31'h0, camera_trigger_o}, 32'h0, "idle level low");
        p0 = pulses;
        wr(ctg_pkg::IDX_CTL, 8'h48);
        count_lvl(1'b1, 60, c);
        check(c, 8, "one-shot length");
        check(pulses - p0, 32'h1, "single pulse seen");
        xfer(1'b0, ctg_pkg::IDX_CTL, 32'h0, rd);
        check(rd, 32'h40, "one-shot bit reads 0");
        wr(ctg_pkg::IDX_CTL, 8'h44);
        repeat (4) @(posedge clock_i);
        wr(ctg_pkg::IDX_CTL, 8'h4C);
        count_lvl(1'b0, 60, c);
        check(c, 8, "inverted one-shot length");
        // External pins follow one clock late
        for (int k = 0; k < 7; k++)
        begin
            wr(ctg_pkg::IDX_CTL, {4'(8 + k), 4'b0000});
            gpio_i <= 7'(1 << k);
            repeat (3) @(posedge clock_i);
            check({31'h0, camera_trigger_o}, 32'h1, "gpio high passed");
            gpio_i <= ~7'(1 << k);
            repeat (3) @(posedge clock_i);
            check({31'h0, camera_trigger_o}, 32'h0, "gpio low passed");
        end
        give_verdict();
    end
endmodule
